// file: brt_regs.vh
// Constants for the buffer memory access sequencer.
// Assumes a single system clock and a register write port supplied by the
// microcontroller interface logic of the surrounding controller.
//
// Behaviour
// [RQ1] SRAM access lasts a count of clock periods set by timing register bits 1-0.
// [RQ2] DRAM row strobe low and high widths come from timing register bits 3-0.
// [RQ3] Column strobe falls one clock after the row strobe falls.
// [RQ4] Column strobe rises together with the row strobe.
// [RQ5] Output enable follows column strobe on reads; stays high on writes and refresh.
// [RQ6] Writes are early writes; write strobe follows the row strobe. Page-hit writes leave the write strobe at the level the row-opening access set.
// [RQ7] Write data valid by column strobe fall and held while it is low.
// [RQ8] Column address held unchanged while the column strobe is low.
// [RQ9] Page mode keeps row strobe low and pulses column strobe per access.
// [RQ10] Refresh pulses row strobe only, no output enable and no write strobe.
`ifndef BRT_REGS_VH
`define BRT_REGS_VH

// ==========================================================
// Register map
`define BRT_ADDR_W          8
`define BRT_TIMING_OFS      8'h54
`define BRT_TIMING_RST      8'h00

// ==========================================================
// Timing register fields
`define BRT_SRAM_LEN_LSB    0
`define BRT_SRAM_LEN_MSB    1
`define BRT_RAS_LOW_LSB     0
`define BRT_RAS_LOW_MSB     1
`define BRT_RAS_HIGH_LSB    2
`define BRT_RAS_HIGH_MSB    3
`define BRT_PG_CL_LSB       4
`define BRT_PG_CL_MSB       5
`define BRT_PG_CH_LSB       6
`define BRT_PG_CH_MSB       7

// ==========================================================
// Access kinds
`define BRT_OP_READ         2'h0
`define BRT_OP_WRITE        2'h1
`define BRT_OP_REFRESH      2'h2

// ==========================================================
// Widths and counters
`define BRT_CNT_W           3
`define BRT_CNT_ONE         3'h1
`define BRT_CNT_ZERO        3'h0
`define BRT_MEM_ADDR_W      11
`define BRT_FULL_ADDR_W     22
`define BRT_DATA_W          8

// ==========================================================
// Request address fields
`define BRT_ROW_MSB         21
`define BRT_ROW_LSB         11
`define BRT_COL_MSB         10
`define BRT_COL_LSB         0
`define BRT_SRAM_A16        16
`define BRT_SRAM_A17        17

`endif

// file: brt_seq.v
// Buffer memory access sequencer: SRAM, normal DRAM, page mode and refresh.
// Assumes the buffer arbiter holds its request until acknowledged and that
// register writes arrive as one-cycle strobes, synchronous to clk_sys.
`include "brt_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module brt_seq
(
   // Clock and reset
   input  wire                          clk_sys,
   input  wire                          srst,
   // Register port
   input  wire                          reg_wr,
   input  wire [`BRT_ADDR_W-1:0]        reg_addr,
   input  wire [7:0]                    reg_wdata,
   output reg  [7:0]                    reg_rdata_q,
   // Configuration
   input  wire                          dram_mode,
   // Access request
   input  wire                          acc_req,
   input  wire [1:0]                    acc_op,
   input  wire                          acc_page,
   input  wire [`BRT_FULL_ADDR_W-1:0]   acc_addr,
   input  wire [`BRT_DATA_W-1:0]        acc_wdata,
   output reg                           acc_ack_q,
   output reg                           acc_done_q,
   output reg  [`BRT_DATA_W-1:0]        acc_rdata_q,
   output reg                           busy_q,
   // Memory pins
   output reg  [`BRT_MEM_ADDR_W-1:0]    mem_addr_q,
   output reg  [`BRT_DATA_W-1:0]        mem_dout_q,
   output reg                           mem_dout_en_q,
   input  wire [`BRT_DATA_W-1:0]        mem_din,
   output reg                           row_strobe_or_addr16_n_q,
   output reg                           col_strobe_or_addr17_n_q,
   output reg                           mem_output_enable_n_q,
   output reg                           mem_write_enable_n_q
);

   // ==========================================================
   // States
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_SRAM  = 3'h1;
   localparam [2:0] ST_RAS   = 3'h2;
   localparam [2:0] ST_CAS   = 3'h3;
   localparam [2:0] ST_PRE   = 3'h4;
   localparam [2:0] ST_PGHI  = 3'h6;

   reg [2:0]                state_q;
   reg [`BRT_CNT_W-1:0]     cnt_q;
   reg [1:0]                op_q;
   reg [`BRT_MEM_ADDR_W-1:0] col_q;
   reg [`BRT_MEM_ADDR_W-1:0] row_q;
   reg                      page_open_q;

   // ==========================================================
   // Timing register and derived counts (field value plus one periods)
   wire [`BRT_CNT_W-1:0] sram_len =
      {1'b0, reg_rdata_q[`BRT_SRAM_LEN_MSB:`BRT_SRAM_LEN_LSB]} + `BRT_CNT_ONE;
   wire [`BRT_CNT_W-1:0] ras_low =
      {1'b0, reg_rdata_q[`BRT_RAS_LOW_MSB:`BRT_RAS_LOW_LSB]} + `BRT_CNT_ONE;
   wire [`BRT_CNT_W-1:0] ras_high =
      {1'b0, reg_rdata_q[`BRT_RAS_HIGH_MSB:`BRT_RAS_HIGH_LSB]} + `BRT_CNT_ONE;
   wire [`BRT_CNT_W-1:0] pg_cl =
      {1'b0, reg_rdata_q[`BRT_PG_CL_MSB:`BRT_PG_CL_LSB]} + `BRT_CNT_ONE;
   wire [`BRT_CNT_W-1:0] pg_ch =
      {1'b0, reg_rdata_q[`BRT_PG_CH_MSB:`BRT_PG_CH_LSB]} + `BRT_CNT_ONE;

   wire is_read  = (op_q == `BRT_OP_READ);
   wire is_write = (op_q == `BRT_OP_WRITE);
   wire same_row = page_open_q && acc_page
                   && (acc_addr[`BRT_ROW_MSB:`BRT_ROW_LSB] == row_q)
                   && (acc_op != `BRT_OP_REFRESH);

   always @(posedge clk_sys)
   begin
      if (srst)
         reg_rdata_q <= `BRT_TIMING_RST;
      else if (reg_wr && (reg_addr == `BRT_TIMING_OFS))
         reg_rdata_q <= reg_wdata;
   end

   // ==========================================================
   // Sequencer
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_q                  <= ST_IDLE;
         cnt_q                    <= `BRT_CNT_ZERO;
         op_q                     <= `BRT_OP_READ;
         col_q                    <= {`BRT_MEM_ADDR_W{1'b0}};
         row_q                    <= {`BRT_MEM_ADDR_W{1'b0}};
         page_open_q              <= 1'b0;
         acc_ack_q                <= 1'b0;
         acc_done_q               <= 1'b0;
         acc_rdata_q              <= {`BRT_DATA_W{1'b0}};
         busy_q                   <= 1'b0;
         mem_addr_q               <= {`BRT_MEM_ADDR_W{1'b0}};
         mem_dout_q               <= {`BRT_DATA_W{1'b0}};
         mem_dout_en_q            <= 1'b0;
         row_strobe_or_addr16_n_q <= 1'b1;
         col_strobe_or_addr17_n_q <= 1'b1;
         mem_output_enable_n_q    <= 1'b1;
         mem_write_enable_n_q     <= 1'b1;
      end
      else
      begin
         acc_ack_q  <= 1'b0;
         acc_done_q <= 1'b0;
         case (state_q)
            ST_IDLE:
            begin
               // An open page is closed in any idle cycle that has no same-row page request
               if (acc_req && !acc_ack_q && page_open_q && same_row)
               begin
                  acc_ack_q                <= 1'b1;
                  busy_q                   <= 1'b1;
                  op_q                     <= acc_op;
                  mem_addr_q               <= acc_addr[`BRT_COL_MSB:`BRT_COL_LSB]; // RQ8
                  mem_dout_q               <= acc_wdata;                        // RQ7
                  mem_dout_en_q            <= (acc_op == `BRT_OP_WRITE);
                  col_strobe_or_addr17_n_q <= 1'b0;                             // RQ9
                  mem_output_enable_n_q    <= (acc_op != `BRT_OP_READ);         // RQ5
                  // Straight into the column phase so the low width is exactly pg_cl
                  cnt_q                    <= pg_cl;                            // RQ9
                  state_q                  <= ST_CAS;
               end
               else if (page_open_q && !(acc_req && !acc_ack_q && same_row))
               begin
                  // Leave page: release row, precharge for the high width
                  row_strobe_or_addr16_n_q <= 1'b1;
                  mem_write_enable_n_q     <= 1'b1;                             // RQ6
                  page_open_q              <= 1'b0;
                  busy_q                   <= 1'b1;
                  cnt_q                    <= ras_high;                         // RQ2
                  state_q                  <= ST_PRE;
               end
               else if (acc_req && !acc_ack_q)
               begin
                  acc_ack_q     <= 1'b1;
                  busy_q        <= 1'b1;
                  op_q          <= acc_op;
                  row_q         <= acc_addr[`BRT_ROW_MSB:`BRT_ROW_LSB];
                  mem_dout_q    <= acc_wdata;                                   // RQ7
                  mem_dout_en_q <= (acc_op == `BRT_OP_WRITE);
                  if (!dram_mode)
                  begin
                     // SRAM: high address bits share the strobe pins
                     mem_addr_q               <= acc_addr[`BRT_COL_MSB:`BRT_COL_LSB];
                     row_strobe_or_addr16_n_q <= acc_addr[`BRT_SRAM_A16];
                     col_strobe_or_addr17_n_q <= acc_addr[`BRT_SRAM_A17];
                     mem_output_enable_n_q    <= (acc_op != `BRT_OP_READ);
                     mem_write_enable_n_q     <= (acc_op != `BRT_OP_WRITE);
                     cnt_q                    <= sram_len;                      // RQ1
                     state_q                  <= ST_SRAM;
                  end
                  else
                  begin
                     mem_addr_q               <= acc_addr[`BRT_ROW_MSB:`BRT_ROW_LSB];
                     row_strobe_or_addr16_n_q <= 1'b0;
                     mem_write_enable_n_q     <= (acc_op != `BRT_OP_WRITE);   // RQ6 RQ10
                     page_open_q              <= acc_page && (acc_op != `BRT_OP_REFRESH);
                     col_q                    <= acc_addr[`BRT_COL_MSB:`BRT_COL_LSB];
                     cnt_q                    <= ras_low;                       // RQ2
                     state_q                  <= ST_RAS;
                  end
               end
               else
                  busy_q <= page_open_q;
            end
            ST_SRAM:
            begin
               if (cnt_q == `BRT_CNT_ONE)
               begin
                  if (is_read)
                     acc_rdata_q <= mem_din;
                  mem_output_enable_n_q <= 1'b1;
                  mem_write_enable_n_q  <= 1'b1;
                  mem_dout_en_q         <= 1'b0;
                  acc_done_q            <= 1'b1;
                  busy_q                <= 1'b0;
                  state_q               <= ST_IDLE;
               end
               cnt_q <= cnt_q - `BRT_CNT_ONE;
            end
            ST_RAS:
            begin
               // One row-strobe-low period, then the column phase
               mem_addr_q <= col_q;                                             // RQ8
               if (op_q != `BRT_OP_REFRESH)
               begin
                  col_strobe_or_addr17_n_q <= 1'b0;                             // RQ3
                  mem_output_enable_n_q    <= !is_read;                         // RQ5
               end
               cnt_q   <= cnt_q - `BRT_CNT_ONE;
               state_q <= (cnt_q == `BRT_CNT_ONE) ? ST_CAS : ST_CAS;
               if (cnt_q == `BRT_CNT_ONE)
                  cnt_q <= `BRT_CNT_ONE;
            end
            ST_CAS:
            begin
               if (cnt_q == `BRT_CNT_ONE)
               begin
                  if (is_read)
                     acc_rdata_q <= mem_din;
                  acc_done_q            <= 1'b1;
                  col_strobe_or_addr17_n_q <= 1'b1;                             // RQ4
                  mem_output_enable_n_q <= 1'b1;                                // RQ5
                  mem_dout_en_q         <= 1'b0;
                  if (page_open_q)
                  begin
                     // The idle cycle that takes the next column counts as a high period
                     cnt_q   <= pg_ch - `BRT_CNT_ONE;                           // RQ9
                     state_q <= (pg_ch == `BRT_CNT_ONE) ? ST_IDLE : ST_PGHI;
                  end
                  else
                  begin
                     row_strobe_or_addr16_n_q <= 1'b1;                          // RQ4
                     mem_write_enable_n_q     <= 1'b1;                          // RQ6 RQ10
                     cnt_q                    <= ras_high;                      // RQ2
                     state_q                  <= ST_PRE;
                  end
               end
               else
                  cnt_q <= cnt_q - `BRT_CNT_ONE;
            end
            ST_PRE:
            begin
               if (cnt_q == `BRT_CNT_ONE)
               begin
                  busy_q  <= 1'b0;
                  state_q <= ST_IDLE;
               end
               cnt_q <= cnt_q - `BRT_CNT_ONE;
            end
            ST_PGHI:
            begin
               if (cnt_q == `BRT_CNT_ONE)
                  state_q <= ST_IDLE;
               cnt_q <= cnt_q - `BRT_CNT_ONE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

endmodule

`default_nettype wire

// file: brt_mem_model.sv
// Behavioural buffer memory facing the sequencer's pins.
// Assumes active-low strobes; the low 8 address bits select a byte.
`timescale 1ns/1ns
`default_nettype none
module brt_mem_model
(
   // Pins
   input wire         clk_sys, dram_mode, cas_n, oe_n, we_n,
   input wire [7:0]   addr, dout,
   output logic [7:0] din
);
   logic [7:0] mem [0:255];
   logic [7:0] last_q = 8'h00;
   // A released bus never keeps its last value, so show the inverse
   assign din = oe_n ? ~last_q : mem[addr];
   always @(posedge clk_sys)
   begin
      if (!we_n && (!dram_mode || !cas_n))
         mem[addr] <= dout;
      if (!oe_n)
         last_q <= mem[addr];
   end
endmodule
`default_nettype wire

// file: brt_seq_sva.sv
// Pin checker for the buffer memory sequencer, bound into brt_seq.
// Assumes one clock domain; strobes are active low and registered.
`include "brt_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module brt_seq_sva
(
   // Watched ports
   input wire                       clk_sys, srst, dram_mode, mem_dout_en_q,
   input wire [7:0]                 reg_rdata_q,
   input wire [`BRT_MEM_ADDR_W-1:0] mem_addr_q,
   input wire [`BRT_DATA_W-1:0]     mem_dout_q,
   input wire                       row_strobe_or_addr16_n_q, col_strobe_or_addr17_n_q,
   input wire                       mem_output_enable_n_q, mem_write_enable_n_q
);
   wire        ras_n = row_strobe_or_addr16_n_q;
   wire        cas_n = col_strobe_or_addr17_n_q;
   wire        oe_n = mem_output_enable_n_q;
   wire        we_n = mem_write_enable_n_q;
   logic [2:0] low_q;
   logic       mode_q;
   // Skip the cycle the mode flips, when the pins still carry address bits
   wire        dm = dram_mode && mode_q;
   always @(posedge clk_sys)
   begin
      mode_q <= dram_mode;
      low_q <= (!oe_n || !we_n) ? low_q + 3'h1 : 3'h0;
   end
   // ======
   // Assertions
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_ras_we_fall; $fell(ras_n) ##0 $fell(we_n); endsequence
   sequence s_cas_fall; $fell(cas_n); endsequence
   property p_sram_len;
      !dram_mode && !mode_q && ($rose(oe_n) || $rose(we_n)) |-> low_q == reg_rdata_q[1:0] + 3'h1;
   endproperty
   a_sram_len: assert property (p_sram_len) else $error("sram strobe width");
   property p_cas_lag; dm ##0 s_ras_we_fall |=> s_cas_fall; endproperty
   a_cas_lag: assert property (p_cas_lag) else $error("cas lag");
   property p_rise; dm && $rose(ras_n) |-> cas_n; endproperty
   a_rise: assert property (p_rise) else $error("cas not up with ras");
   property p_oe_cas; dm && $changed(oe_n) |-> $changed(cas_n) && oe_n == cas_n; endproperty
   a_oe_cas: assert property (p_oe_cas) else $error("oe apart from cas");
   property p_oe_wr; dm && !we_n |-> oe_n; endproperty
   a_oe_wr: assert property (p_oe_wr) else $error("oe low in write");
   property p_we_ras; dm && $changed(we_n) |-> $changed(ras_n) && we_n == ras_n; endproperty
   a_we_ras: assert property (p_we_ras) else $error("we apart from ras");
   property p_wdata;
      dm && !cas_n && !we_n |-> mem_dout_en_q && ($fell(cas_n) || $stable(mem_dout_q));
   endproperty
   a_wdata: assert property (p_wdata) else $error("write data moved");
   property p_col; (dm && !cas_n) [*2] |-> $stable(mem_addr_q); endproperty
   a_col: assert property (p_col) else $error("column address moved");
endmodule
bind brt_seq brt_seq_sva i_sva (.clk_sys, .srst, .dram_mode, .mem_dout_en_q, .reg_rdata_q,
   .mem_addr_q, .mem_dout_q, .row_strobe_or_addr16_n_q, .col_strobe_or_addr17_n_q,
   .mem_output_enable_n_q, .mem_write_enable_n_q);
`default_nettype wire

// file: buffer_ram_access_timing_test.sv
// Self-checking bench for the buffer memory access sequencer.
// Assumes brt_seq, its checker and the memory model are compiled first.
`include "brt_regs.vh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin num_errors++; \
   $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module buffer_ram_access_timing_test;
   typedef struct { logic [7:0] t; logic dm; int w; } brt_row_t;
   logic        clk_sys = 1'h0, srst = 1'h1, reg_wr = 1'h0, dram_mode = 1'h0;
   logic        acc_req = 1'h0, acc_page = 1'h0;
   logic [1:0]  acc_op = 2'h0;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, acc_wdata = 8'h00, rd;
   logic [21:0] acc_addr = 22'h000000;
   wire  [7:0]  reg_rdata_q, acc_rdata_q, mem_dout_q, mem_din;
   wire  [10:0] mem_addr_q;
   wire         ack, done, busy, mem_dout_en_q, ras_n, cas_n, oe_n, we_n;
   int          num_errors = 0, samples_checked = 0, k = 0, c[7] = '{default: 0}, s[7];
   brt_row_t    rows[8] = '{'{8'h00, 1'h0, 1}, '{8'h01, 1'h0, 2}, '{8'h02, 1'h0, 3},
      '{8'h03, 1'h0, 4}, '{8'h05, 1'h1, 2}, '{8'h06, 1'h1, 3}, '{8'h0B, 1'h1, 4},
      '{8'h0D, 1'h1, 2}};
   brt_seq i_dut (.clk_sys, .srst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata_q, .dram_mode,
      .acc_req, .acc_op, .acc_page, .acc_addr, .acc_wdata, .acc_ack_q(ack), .acc_done_q(done),
      .acc_rdata_q, .busy_q(busy), .mem_addr_q, .mem_dout_q, .mem_dout_en_q, .mem_din,
      .row_strobe_or_addr16_n_q(ras_n), .col_strobe_or_addr17_n_q(cas_n),
      .mem_output_enable_n_q(oe_n), .mem_write_enable_n_q(we_n));
   brt_mem_model i_mem (.clk_sys, .dram_mode, .cas_n, .oe_n, .we_n, .addr(mem_addr_q[7:0]),
      .dout(mem_dout_q), .din(mem_din));
   always #25 clk_sys = ~clk_sys;
   // Strobe tallies; scenarios compare differences against the last snapshot in s
   always @(posedge clk_sys)
      c <= '{c[0] + !ras_n, c[1] + $fell(ras_n), c[2] + $fell(cas_n), c[3] + !oe_n,
             c[4] + !we_n, c[5] + (ras_n && busy), c[6] + !cas_n};
   function automatic int d(int i); return c[i] - s[i]; endfunction
   task step(inout int n);
      @(posedge clk_sys);
      #1;
      n++;
   endtask
   task wreg(input logic [7:0] a, v);
      {reg_wr, reg_addr, reg_wdata} = {1'h1, a, v};
      step(k);
      reg_wr = 1'h0;
      step(k);
   endtask
   task acc(input logic [1:0] op, input logic pg, fin, input logic [7:0] col);
      int n;
      n = 0;
      {acc_op, acc_page, acc_addr} = {op, pg, 14'h0300, col};
      {acc_wdata, acc_req} = {8'h5A ^ col, 1'h1};
      do step(n); while (ack !== 1'h1 && n < 40);
      acc_req = 1'h0;
      while (done !== 1'h1 && (busy !== 1'h0 || op != 2'h2) && n < 40) step(n);
      rd = acc_rdata_q;
      while (fin && busy !== 1'h0 && n < 40) step(n);
      `CHK("handshake", 1'h1, n < 40)
   endtask
   task end_of_test;
      $display("checked %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #400000;
      num_errors++;
      end_of_test;
   end
   initial
   begin
      repeat (12) step(k);
      srst = 1'h0;
      `CHK("timing reset", `BRT_TIMING_RST, reg_rdata_q)
      foreach (rows[i])
      begin
         wreg(`BRT_TIMING_OFS, rows[i].t);
         `CHK("timing reg", rows[i].t, reg_rdata_q)
         dram_mode = rows[i].dm;
         s = c;
         acc(`BRT_OP_WRITE, 1'h0, 1'h1, 8'h10 + i[7:0]);
         `CHK("write strobe width", rows[i].w, d(4))
         `CHK("oe on write", 0, d(3))
         s = c;
         acc(`BRT_OP_READ, 1'h0, 1'h1, 8'h10 + i[7:0]);
         `CHK("read data", 8'h5A ^ (8'h10 + i[7:0]), rd)
         `CHK("oe width", rows[i].w - rows[i].dm, d(3))
         if (rows[i].dm) `CHK("ras low width", rows[i].w, d(0))
      end
      // Refresh: row low 2, row high 4
      wreg(`BRT_TIMING_OFS, 8'h0D);
      s = c;
      acc(`BRT_OP_REFRESH, 1'h0, 1'h1, 8'h00);
      `CHK("refresh low", 2, d(0))
      `CHK("refresh high", 4, d(5))
      `CHK("refresh others", 0, d(2) + d(3) + d(4))
      // Page mode: two page reads in one row, then a plain read in that row closes it
      wreg(`BRT_TIMING_OFS, 8'h51);
      s = c;
      acc(`BRT_OP_READ, 1'h1, 1'h0, 8'h16);
      `CHK("page read 1", 8'h4C, rd)
      s[6] = c[6];
      acc(`BRT_OP_READ, 1'h1, 1'h0, 8'h17);
      `CHK("page read 2", 8'h4D, rd)
      `CHK("page col low", 2, d(6))
      `CHK("page row held", 1, d(1))
      acc(`BRT_OP_READ, 1'h0, 1'h1, 8'h16);
      // The closing access opens the row again, so two falls in all
      `CHK("page row falls", 2, d(1))
      `CHK("page col falls", 3, d(2))
      wreg(8'h55, 8'hFF);
      `CHK("unmapped write", 8'h51, reg_rdata_q)
      // Reset in mid-access: pins go idle, then the first access right after
      {acc_op, acc_addr, acc_req} = {`BRT_OP_READ, 14'h0300, 8'h11, 1'h1};
      step(k);
      acc_req = 1'h0;
      srst = 1'h1;
      step(k);
      step(k);
      srst = 1'h0;
      `CHK("reset strobes", 4'hF, {ras_n, cas_n, oe_n, we_n})
      `CHK("reset timing", `BRT_TIMING_RST, reg_rdata_q)
      acc(`BRT_OP_READ, 1'h0, 1'h1, 8'h11);
      `CHK("read after reset", 8'h4B, rd)
      end_of_test;
   end
endmodule
`default_nettype wire
